// file: hw/lrx_defs.vh
`ifndef LRX_DEFS_VH
`define LRX_DEFS_VH

// operation select codes on op_sel_in
`define LRX_OP_NONE 3'h0
`define LRX_OP_RETLIT 3'h1
`define LRX_OP_SWAP 3'h2
`define LRX_OP_XORF 3'h3
`define LRX_OP_XORL 3'h4

// destination bit values
`define LRX_DEST_ACC 1'b0
`define LRX_DEST_FILE 1'b1

// reset values
`define LRX_ACC_RST 8'h00
`define LRX_ZERO_RST 1'b0

// cycle counts per operation
`define LRX_CYC_RETLIT 2
`define LRX_CYC_SINGLE 1

`endif

// file: hw/lrx_alu.v
`timescale 1ns/100ps
`include "lrx_defs.vh"
// ----------------------------------------
// result datapath
// ----------------------------------------
module lrx_alu #(
  parameter WIDTH = 8
) (
  input wire [2:0] op_in,
  input wire [WIDTH-1:0] acc_in,
  input wire [WIDTH-1:0] file_in,
  input wire [WIDTH-1:0] lit_in,
  output reg [WIDTH-1:0] res_out,
  output wire zero_out
);

  always @*
  begin
    case (op_in)
      // [RULE_03] nibble exchange
      `LRX_OP_SWAP: res_out = {file_in[WIDTH/2-1:0], file_in[WIDTH-1:WIDTH/2]};
      // [RULE_05] register xor
      `LRX_OP_XORF: res_out = acc_in ^ file_in;
      // [RULE_06] literal xor
      `LRX_OP_XORL: res_out = acc_in ^ lit_in;
      // [RULE_01] literal passthrough
      `LRX_OP_RETLIT: res_out = lit_in;
      default: res_out = acc_in;
    endcase
  end

  // [RULE_07] all-zero detect
  assign zero_out = (res_out == {WIDTH{1'b0}});

endmodule // lrx_alu

// file: hw/lrx_exec.v
`timescale 1ns/100ps
`include "lrx_defs.vh"

// Overview of operation
// [RULE_01] return-with-literal loads accumulator, pops pc
// [RULE_02] return-with-literal takes two instruction cycles
// [RULE_03] swap exchanges file register nibbles, flags kept
// [RULE_04] swap destination bit picks accumulator or file
// [RULE_05] register xor to chosen destination, zero updated
// [RULE_06] literal xor into accumulator, zero updated
// [RULE_07] zero flag set when xor result zero
module lrx_exec #(
  parameter WIDTH = 8,
  parameter ADDR_W = 7,
  parameter PC_W = 13
) (
  input wire mclk_in,
  input wire rst_in,
  input wire cyc_en_in,
  input wire issue_in,
  input wire [2:0] op_sel_in,
  input wire [WIDTH-1:0] literal_in,
  input wire [ADDR_W-1:0] file_addr_in,
  input wire dest_in,
  input wire [WIDTH-1:0] file_rdata_in,
  input wire [PC_W-1:0] stack_top_entry_in,
  output wire busy_out,
  output wire [ADDR_W-1:0] file_raddr_out,
  output reg file_we_out,
  output reg [ADDR_W-1:0] file_waddr_out,
  output reg [WIDTH-1:0] file_wdata_out,
  output reg stack_pop_out,
  output reg pc_load_out,
  output reg [PC_W-1:0] pc_value_out,
  output reg flush_out,
  output wire [WIDTH-1:0] acc_out,
  output wire zero_flag_out
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam ST_RUN = 1'b0;
  localparam ST_FLUSH = 1'b1;

  reg state_q;
  reg state_d;
  reg [WIDTH-1:0] acc_q;
  reg [WIDTH-1:0] acc_d;
  reg zero_q;
  reg zero_d;
  reg file_we_d;
  reg [ADDR_W-1:0] file_waddr_d;
  reg [WIDTH-1:0] file_wdata_d;
  reg [PC_W-1:0] pc_value_d;
  wire [WIDTH-1:0] res;
  wire res_zero;
  wire take;
  wire ret_take;
  wire to_file;

  // a new operation is only taken on an instruction-cycle enable
  assign take = cyc_en_in & issue_in & (state_q == ST_RUN);
  assign ret_take = take & (op_sel_in == `LRX_OP_RETLIT);
  // [RULE_04] destination bit decode
  assign to_file = (dest_in == `LRX_DEST_FILE);
  assign busy_out = (state_q == ST_FLUSH);
  assign file_raddr_out = file_addr_in;
  assign acc_out = acc_q;
  assign zero_flag_out = zero_q;

  // ----------------------------------------
  // result datapath
  // ----------------------------------------
  lrx_alu #(
    .WIDTH(WIDTH)
  ) u_alu (
    .op_in(op_sel_in),
    .acc_in(acc_q),
    .file_in(file_rdata_in),
    .lit_in(literal_in),
    .res_out(res),
    .zero_out(res_zero)
  );

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // the word fetched behind a return is dropped by refusing the next slot
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
      begin
        // [RULE_02] return opens flush
        if (ret_take)
        begin
          state_d = ST_FLUSH;
        end
      end
      ST_FLUSH:
      begin
        // [RULE_02] discard prefetched word
        if (cyc_en_in)
        begin
          state_d = ST_RUN;
        end
      end
      default:
      begin
        state_d = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always @*
  begin
    acc_d = acc_q;
    zero_d = zero_q;
    file_we_d = 1'b0;
    file_waddr_d = file_waddr_out;
    file_wdata_d = file_wdata_out;
    pc_value_d = pc_value_out;
    if (take)
    begin
      case (op_sel_in)
        `LRX_OP_RETLIT:
        begin
          // [RULE_01] load literal, pop pc
          acc_d = res;
          pc_value_d = stack_top_entry_in;
        end
        `LRX_OP_SWAP:
        begin
          // [RULE_04] destination select, flags untouched
          if (to_file)
          begin
            file_we_d = 1'b1;
            file_waddr_d = file_addr_in;
            file_wdata_d = res;
          end
          else
          begin
            acc_d = res;
          end
        end
        `LRX_OP_XORF:
        begin
          // [RULE_05] xor to destination
          if (to_file)
          begin
            file_we_d = 1'b1;
            file_waddr_d = file_addr_in;
            file_wdata_d = res;
          end
          else
          begin
            acc_d = res;
          end
          // [RULE_07] zero flag update
          zero_d = res_zero;
        end
        `LRX_OP_XORL:
        begin
          // [RULE_06] xor literal
          acc_d = res;
          // [RULE_07] zero flag update
          zero_d = res_zero;
        end
        default:
        begin
          // unused codes use up the slot but change nothing
          acc_d = acc_q;
        end
      endcase
    end
  end

  // ----------------------------------------
  // core registers
  // ----------------------------------------
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_RUN;
      acc_q <= `LRX_ACC_RST;
      zero_q <= `LRX_ZERO_RST;
    end
    else
    begin
      state_q <= state_d;
      acc_q <= acc_d;
      zero_q <= zero_d;
    end
  end

  // ----------------------------------------
  // file, stack and pc ports
  // ----------------------------------------
  // pulses last one clock; address, data and pc hold for the consumer
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      file_we_out <= 1'b0;
      file_waddr_out <= {ADDR_W{1'b0}};
      file_wdata_out <= {WIDTH{1'b0}};
      stack_pop_out <= 1'b0;
      pc_load_out <= 1'b0;
      pc_value_out <= {PC_W{1'b0}};
      flush_out <= 1'b0;
    end
    else
    begin
      file_we_out <= file_we_d;
      file_waddr_out <= file_waddr_d;
      file_wdata_out <= file_wdata_d;
      // [RULE_01] pop and reload together
      stack_pop_out <= ret_take;
      pc_load_out <= ret_take;
      pc_value_out <= pc_value_d;
      // [RULE_02] second cycle flushes
      flush_out <= ret_take;
    end
  end

endmodule // lrx_exec

// file: sim/lrx_exec_chk.sv
`timescale 1ns/100ps
module lrx_exec_chk (
  input wire mclk_in, rst_in, cyc_en_in, issue_in, dest_in, busy_out, file_we_out,
  input wire stack_pop_out, pc_load_out, flush_out, zero_flag_out,
  input wire [2:0] op_sel_in,
  input wire [7:0] literal_in, file_rdata_in, acc_out, file_wdata_out,
  input wire [12:0] stack_top_entry_in, pc_value_out,
  input wire [6:0] file_addr_in, file_waddr_out, file_raddr_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // op actually taken; refused slots read as 0
  wire [2:0] o = cyc_en_in && issue_in && !busy_out ? op_sel_in : 3'h0;
  wire [7:0] s = {file_rdata_in[3:0], file_rdata_in[7:4]};
  wire [7:0] x = acc_out ^ (op_sel_in[2] ? literal_in : file_rdata_in);
  AST_RET: assert property (o == 1 |=> acc_out == $past(literal_in) &&
    stack_pop_out && pc_load_out && pc_value_out == $past(stack_top_entry_in)
    && $stable(zero_flag_out)) else $error("ret");
  AST_FLUSH: assert property (o == 1 |=> busy_out && flush_out) else $error("flush");
  AST_SWAP: assert property (o == 2 && !dest_in |=> acc_out == $past(s)
    && !file_we_out && $stable(zero_flag_out)) else $error("swap");
  AST_SWDST: assert property (o == 2 && dest_in |=> file_we_out
    && file_wdata_out == $past(s) && $stable(acc_out)) else $error("swdst");
  AST_XORF: assert property (o == 3 |=> file_we_out == $past(dest_in)
    && (file_we_out ? file_wdata_out : acc_out) == $past(x)) else $error("xorf");
  AST_XORL: assert property (o == 4 |=> acc_out == $past(x)) else $error("xorl");
  AST_ZERO: assert property (o == 3 || o == 4 |=> zero_flag_out == ($past(x) == 0))
    else $error("zero");
  AST_WADDR: assert property ((o == 2 || o == 3) && dest_in |=>
    file_waddr_out == $past(file_addr_in)) else $error("waddr");
  AST_RADDR: assert property (file_raddr_out == file_addr_in) else $error("raddr");
endmodule // lrx_exec_chk

bind lrx_exec lrx_exec_chk lrx_exec_chk_inst (.*);

// file: sim/lrx_exec_bench.sv
`timescale 1ns/100ps
module lrx_exec_bench;
  reg c = 0, rs = 1, cy = 0, is = 0, d = 0, ez = 0, eb = 0, fw = 0, tk;
  reg [2:0] op = 0;
  reg [7:0] lt = 0, rd = 0, ea = 0, sw = 0;
  reg [6:0] fa = 0, ew = 0;
  wire [6:0] wa, ra;
  reg [12:0] st = 0, ep = 0;
  integer seed = 32'h3e26fcc5, err_total = 0, cmp_count = 0, r, q, n;
  wire [7:0] a, wd;
  wire [12:0] pc;
  wire b, we, z;
  always #12.5 c = ~c;
  lrx_exec lrx_exec_inst (.mclk_in(c), .rst_in(rs), .cyc_en_in(cy), .issue_in(is),
    .op_sel_in(op), .literal_in(lt), .file_addr_in(fa), .dest_in(d),
    .file_rdata_in(rd), .stack_top_entry_in(st), .busy_out(b), .file_raddr_out(ra),
    .file_we_out(we), .file_waddr_out(wa), .file_wdata_out(wd), .stack_pop_out(),
    .pc_load_out(), .pc_value_out(pc), .flush_out(), .acc_out(a), .zero_flag_out(z));
  function [7:0] swp(input [7:0] v);
    swp = {v[3:0], v[7:4]};
  endfunction
  task chk(input [39:0] nm, input [12:0] s, e);
    begin
      cmp_count++;
      if (s !== e)
      begin
        err_total++;
        $display("Error %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task test_done;
    begin
      $display("compares %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // watchdog, run needs about 23 us
  initial
  begin
    #90000 err_total++;
    test_done;
  end
  initial
  begin
    repeat (5) @(negedge c);
    rs = 0;
    for (n = 0; n < 900; n = n + 1)
    begin
      @(negedge c);
      chk("acc", a, ea);
      chk("zero", z, ez);
      chk("busy", b, eb);
      chk("pc", pc, ep);
      chk("we", we, fw);
      if (fw) chk("wdata", wd, sw);
      chk("waddr", wa, ew);
      chk("raddr", ra, fa);
      r = $random(seed);
      q = $random(seed);
      fa = r[16:10];
      // back-to-back returns first, so one lands in the flush slot
      {cy, is, d, op} = (n < 4) ? 6'h31 : r[5:0];
      lt = r[7:6] ? q[7:0] : ea;
      rd = r[9:8] ? q[15:8] : ea;
      st = q[28:16];
      fw = 0;
      tk = cy && is && !eb;
      if (cy && eb)
        eb = 0;
      else if (tk)
        case (op)
          1: {ea, ep, eb} = {lt, st, 1'b1};
          2: {sw, fw} = {swp(rd), d};
          3: {sw, fw, ez} = {ea ^ rd, d, ea == rd};
          4: {ea, ez} = {ea ^ lt, ea == lt};
        endcase
      if (tk && !d && (op == 2 || op == 3))
        ea = sw;
      if (fw)
        ew = fa;
    end
    $display("random run done");
    test_done;
  end
endmodule // lrx_exec_bench
